// *** design/cmdsg_counter.v ***
// Notes on behaviour
// - Mode letter comes only from gate field and special, reload, repeat bits.
// - Repeat bit 0 disarms after sequence; repeat bit 1 keeps counting.
// - Modes N, O, Q, R: gate edge copies count to hold, then reloads.
// - Modes N and Q count source edges only while gate is active.
// - Modes O, R, X start on gate edge, stop at next terminal count.
// - Modes N and O reach terminal count once then disarm.
// - Modes Q, R, V, X count to terminal count repeatedly, never disarm.
// - Modes N, O, Q, R, X reload from load register at terminal count.
// - Modes S and V reload from load if gate low, hold if high.
// - In modes S and V the gate never qualifies source edges.
// - Mode S reaches terminal count twice then disarms.
// - Mode X gate edge captures count into hold without retriggering.
// - Stop or disarm takes effect after the edge leaving terminal count.
// - In terminal count the next source edge counts, unless an armed gate edge in modes N, O, Q, R, X takes the same cycle.
// - Only active-going source and gate transitions are events.
// - All-zero mode bits decode mode A, gate has no effect.
// - Mode A counts after arm, reloads and disarms at terminal count.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "cmdsg_regs.vh"

module cmdsg_counter
#(
   parameter WIDTH = 16
)
(
   input  wire                ref_clk,
   input  wire                reset_n,
   input  wire [3:0]          avs_address,
   input  wire                avs_read,
   input  wire                avs_write,
   input  wire [31:0]         avs_writedata,
   input  wire [3:0]          avs_byteenable,
   output reg  [31:0]         avs_readdata,
   output wire                avs_waitrequest,
   input  wire                gate_pin,
   input  wire                source_pin,
   output wire                terminal_count,
   output reg                 armed,
   output wire                irq
);

   // ****************************************************************
   // Mode codes
   // ****************************************************************
   localparam [3:0] MODE_A     = 4'h0;
   localparam [3:0] MODE_N     = 4'h1;
   localparam [3:0] MODE_O     = 4'h2;
   localparam [3:0] MODE_Q     = 4'h3;
   localparam [3:0] MODE_R     = 4'h4;
   localparam [3:0] MODE_S     = 4'h5;
   localparam [3:0] MODE_V     = 4'h6;
   localparam [3:0] MODE_X     = 4'h7;
   localparam [3:0] MODE_OTHER = 4'hF;

   localparam [2:0] GATE_NONE  = 3'h0;

   // Decode mode letter from config bits
   function [3:0] decode_mode;
      input [15:0] cfg;
      reg   [2:0]  gsel;
      reg   [2:0]  sel;
      begin
         gsel = cfg[`CMDSG_GATE_HI:`CMDSG_GATE_LO];
         sel  = {cfg[`CMDSG_SPECIAL_BIT], cfg[`CMDSG_RELOAD_BIT], cfg[`CMDSG_REPEAT_BIT]};
         decode_mode = MODE_OTHER;
         if (gsel == GATE_NONE && sel == 3'h0)
            decode_mode = MODE_A;
         else if (sel == 3'h4 && gsel != GATE_NONE)
            decode_mode = gsel[2] ? MODE_O : MODE_N;
         else if (sel == 3'h5 && gsel != GATE_NONE)
            decode_mode = gsel[2] ? MODE_R : MODE_Q;
         else if (sel == 3'h6 && gsel == GATE_NONE)
            decode_mode = MODE_S;
         else if (sel == 3'h7 && gsel == GATE_NONE)
            decode_mode = MODE_V;
         else if (sel == 3'h7 && gsel[2])
            decode_mode = MODE_X;
      end
   endfunction

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   reg  [15:0]      config_reg;
   reg  [WIDTH-1:0] load_reg;
   reg  [WIDTH-1:0] hold_reg;
   reg  [WIDTH-1:0] count;
   reg  [2:0]       irq_status;
   reg  [2:0]       irq_mask;
   reg              running;
   reg              second_tc;
   reg              stop_pending;
   reg              disarm_pending;
   reg              in_tc;
   reg              read_done;
   reg  [1:0]       gate_sync;
   reg  [1:0]       source_sync;
   reg              gate_prev;
   reg              source_prev;

   wire [3:0]       mode;
   wire             gate_lvl;
   wire             gate_edge;
   wire             source_edge;
   wire             at_tc;
   wire             retrig_mode;
   wire             level_mode;
   wire             edge_start_mode;
   wire             qualified;
   wire             count_step;
   wire             wr_cmd;
   wire [2:0]       irq_set;

   assign mode = decode_mode(config_reg);

   // Pin synchronisers
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_sync   <= 2'h0;
         source_sync <= 2'h0;
         gate_prev   <= 1'b0;
         source_prev <= 1'b0;
      end
      else
      begin
         gate_sync   <= {gate_sync[0], gate_pin};
         source_sync <= {source_sync[0], source_pin};
         gate_prev   <= gate_sync[1];
         source_prev <= source_sync[1];
      end
   end

   // Rising edges only are events
   assign gate_lvl    = gate_sync[1];
   assign gate_edge   = gate_sync[1] & ~gate_prev;
   assign source_edge = source_sync[1] & ~source_prev;

   // ****************************************************************
   // Mode qualification
   // ****************************************************************
   // Terminal-count state spans the reload edge up to the next source edge
   // A zero count from a load of zero counts as terminal count as well
   assign at_tc           = (count == {WIDTH{1'b0}}) || in_tc;
   assign terminal_count  = at_tc;
   assign retrig_mode     = (mode == MODE_N) || (mode == MODE_O) ||
                            (mode == MODE_Q) || (mode == MODE_R);
   assign level_mode      = (mode == MODE_N) || (mode == MODE_Q);
   assign edge_start_mode = (mode == MODE_O) || (mode == MODE_R) || (mode == MODE_X);

   // Gate level qualifies only modes N and Q
   assign qualified = armed && (mode != MODE_OTHER) &&
                      (level_mode ? gate_lvl : 1'b1) &&
                      (edge_start_mode ? running : 1'b1);

   // Terminal count state counts unless an armed gate edge in modes N, O, Q, R, X takes the same cycle
   assign count_step = source_edge && (at_tc || qualified);

   assign wr_cmd = avs_write && (avs_address == `CMDSG_ADDR_CMD) && avs_byteenable[0];

   assign irq_set[`CMDSG_IRQ_TC]      = count_step && (count == {{(WIDTH-1){1'b0}}, 1'b1});
   assign irq_set[`CMDSG_IRQ_DISARM]  = disarm_pending && source_edge;
   assign irq_set[`CMDSG_IRQ_CAPTURE] = gate_edge && armed &&
                                        (retrig_mode || mode == MODE_X);

   // ****************************************************************
   // Counter sequencing
   // ****************************************************************
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count          <= `CMDSG_COUNT_RST;
         hold_reg       <= `CMDSG_HOLD_RST;
         armed          <= 1'b0;
         running        <= 1'b0;
         second_tc      <= 1'b0;
         stop_pending   <= 1'b0;
         disarm_pending <= 1'b0;
         in_tc          <= 1'b0;
      end
      else
      begin
         // Host hold write
         if (avs_write && avs_address == `CMDSG_ADDR_HOLD)
            hold_reg <= avs_writedata[WIDTH-1:0];
         if (wr_cmd && avs_writedata[`CMDSG_CMD_ARM])
         begin
            armed     <= 1'b1;
            second_tc <= 1'b0;
         end
         if (wr_cmd && avs_writedata[`CMDSG_CMD_DISARM])
            armed <= 1'b0;
         // Software load clears in_tc; a load of zero still leaves terminal count set
         if (wr_cmd && avs_writedata[`CMDSG_CMD_LOAD])
         begin
            count <= load_reg;
            in_tc <= 1'b0;
         end
         // Gate edge: capture then retrigger
         if (gate_edge && armed && retrig_mode)
         begin
            hold_reg <= count;
            count    <= load_reg;
            in_tc    <= 1'b0;
            running  <= 1'b1;
         end
         else if (gate_edge && armed && mode == MODE_X)
         begin
            hold_reg <= count;
            running  <= 1'b1;
         end
         else if (count_step)
         begin
            if (at_tc)
            begin
               // Leaving terminal count applies pending stop or disarm
               if (stop_pending)
                  running <= 1'b0;
               if (disarm_pending)
               begin
                  armed   <= 1'b0;
                  running <= 1'b0;
               end
               stop_pending   <= 1'b0;
               in_tc          <= 1'b0;
               disarm_pending <= 1'b0;
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
            else if (count == {{(WIDTH-1){1'b0}}, 1'b1})
            begin
               // Reaching terminal count: reload and schedule
               in_tc <= 1'b1;
               if (mode == MODE_S || mode == MODE_V)
                  count <= gate_lvl ? hold_reg : load_reg;
               else
                  count <= load_reg;
               if (mode == MODE_A || mode == MODE_N || mode == MODE_O)
                  disarm_pending <= 1'b1;
               if (mode == MODE_S)
               begin
                  second_tc <= ~second_tc;
                  if (second_tc)
                     disarm_pending <= 1'b1;
               end
               if (edge_start_mode)
                  stop_pending <= 1'b1;
            end
            else
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_reg <= `CMDSG_CONFIG_RST;
         load_reg   <= `CMDSG_LOAD_RST;
         irq_mask   <= `CMDSG_MASK_RST;
         irq_status <= 3'h0;
      end
      else
      begin
         if (avs_write && avs_address == `CMDSG_ADDR_CONFIG)
         begin
            if (avs_byteenable[0])
               config_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
               config_reg[15:8] <= avs_writedata[15:8];
         end
         if (avs_write && avs_address == `CMDSG_ADDR_LOAD)
            load_reg <= avs_writedata[WIDTH-1:0];
         if (avs_write && avs_address == `CMDSG_ADDR_MASK && avs_byteenable[0])
            irq_mask <= avs_writedata[2:0];
         // Set wins over write-one-to-clear
         if (avs_write && avs_address == `CMDSG_ADDR_IRQ && avs_byteenable[0])
            irq_status <= (irq_status & ~avs_writedata[2:0]) | irq_set;
         else
            irq_status <= irq_status | irq_set;
      end
   end

   assign irq             = |(irq_status & irq_mask);

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   // Writes finish at once; a read waits one cycle so that the
   // registered read data already stands when waitrequest drops
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         read_done <= 1'b0;
      else
         read_done <= avs_read && !read_done;
   end

   // Held high only in the first cycle of a read
   assign avs_waitrequest = avs_read && !read_done;

   // Read data register, loaded in the first read cycle
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && !read_done)
      begin
         if (avs_address == `CMDSG_ADDR_CONFIG)
            avs_readdata <= {16'h0000, config_reg};
         else if (avs_address == `CMDSG_ADDR_LOAD)
            avs_readdata <= {16'h0000, load_reg};
         else if (avs_address == `CMDSG_ADDR_HOLD)
            avs_readdata <= {16'h0000, hold_reg};
         else if (avs_address == `CMDSG_ADDR_COUNT)
            avs_readdata <= {16'h0000, count};
         else if (avs_address == `CMDSG_ADDR_STATUS)
            avs_readdata <= {24'h000000, mode, second_tc, running, at_tc, armed};
         else if (avs_address == `CMDSG_ADDR_IRQ)
            avs_readdata <= {29'h00000000, irq_status};
         else if (avs_address == `CMDSG_ADDR_MASK)
            avs_readdata <= {29'h00000000, irq_mask};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

endmodule

// *** design/cmdsg_regs.vh ***
`ifndef CMDSG_REGS_VH
`define CMDSG_REGS_VH
// Register word addresses (byte address = 4 * word)
`define CMDSG_ADDR_CONFIG   4'h0
`define CMDSG_ADDR_LOAD     4'h1
`define CMDSG_ADDR_HOLD     4'h2
`define CMDSG_ADDR_COUNT    4'h3
`define CMDSG_ADDR_CMD      4'h4
`define CMDSG_ADDR_STATUS   4'h5
`define CMDSG_ADDR_IRQ      4'h6
`define CMDSG_ADDR_MASK     4'h7
// Config field positions
`define CMDSG_GATE_HI       15
`define CMDSG_GATE_LO       13
`define CMDSG_SPECIAL_BIT   7
`define CMDSG_RELOAD_BIT    6
`define CMDSG_REPEAT_BIT    5
// Command bits
`define CMDSG_CMD_ARM       0
`define CMDSG_CMD_LOAD      1
`define CMDSG_CMD_DISARM    2
// Interrupt status bits
`define CMDSG_IRQ_TC        0
`define CMDSG_IRQ_DISARM    1
`define CMDSG_IRQ_CAPTURE   2
// Reset values
`define CMDSG_CONFIG_RST    16'h0000
`define CMDSG_LOAD_RST      16'h0000
`define CMDSG_HOLD_RST      16'h0000
`define CMDSG_COUNT_RST     16'h0000
`define CMDSG_MASK_RST      3'h0
`endif

// *** sim/cmdsg_counter_sva.sv ***
`timescale 1ns/1ps
// ****
// Port checker
// ****
module cmdsg_counter_sva
(
   input wire        ref_clk,
   input wire        reset_n,
   input wire [3:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        gate_pin,
   input wire        source_pin,
   input wire        terminal_count,
   input wire        armed,
   input wire        irq
);
   reg       src_q;
   reg [3:0] src_age;
   wire      cmd_wr = avs_write && avs_address == 4'h4 && avs_byteenable[0];
   // Cycles since the last source rise
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         src_q   <= 1'b0;
         src_age <= 4'hF;
      end
      else
      begin
         src_q   <= source_pin;
         src_age <= (source_pin && !src_q) ? 4'h0 : src_age + {3'h0, src_age != 4'hF};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_arm_sets: assert property (cmd_wr && avs_writedata[0] && !avs_writedata[2] |=> armed)
      else $error("arm command ignored");
   a_disarm_clears: assert property (cmd_wr && avs_writedata[2] && !avs_writedata[0] |=> !armed)
      else $error("disarm command ignored");
   a_arm_cause: assert property ($rose(armed) |-> $past(cmd_wr && avs_writedata[0]))
      else $error("armed without command");
   a_auto_disarm: assert property ($fell(armed) && !$past(cmd_wr) |-> src_age <= 4'h6)
      else $error("disarm without source edge");
   a_tc_cause: assert property ($rose(terminal_count) |->
      src_age <= 4'h6 || $past(avs_write) || $past(avs_write, 2))
      else $error("terminal count without cause");
   a_armed_quiet: assert property (src_age > 4'h6 && !$past(avs_write) |-> $stable(armed))
      else $error("armed changed without event");
   a_mask_off: assert property (avs_write && avs_address == 4'h7 && avs_byteenable[0]
      && avs_writedata[2:0] == 3'h0 |=> !irq)
      else $error("irq high with mask clear");
   a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   a_read_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
      else $error("read answered before data stands");
endmodule
bind cmdsg_counter cmdsg_counter_sva u_sva (.ref_clk(ref_clk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gate_pin(gate_pin),
   .source_pin(source_pin), .terminal_count(terminal_count), .armed(armed), .irq(irq));

// *** sim/tb_counter_mode_decode_special_gate.sv ***
`timescale 1ns/1ps
`include "cmdsg_regs.vh"
// ****
// Bench top
// ****
module tb_counter_mode_decode_special_gate;
   localparam [127:0] CFGS = {16'h80E0, 16'h00E0, 16'h00C0, 16'h80A0,
                              16'h20A0, 16'h8080, 16'h2080, 16'h0000};
   reg         ref_clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [3:0]  avs_address = 4'h0;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg  [3:0]  avs_byteenable = 4'hF;
   reg         gate_pin = 1'b0;
   reg         source_pin = 1'b0;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, terminal_count, armed, irq;
   reg  [31:0] d;
   integer     mismatches = 0;
   integer     checked = 0;
   integer     i, ld, n, seed;
   cmdsg_counter u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gate_pin(gate_pin), .source_pin(source_pin),
      .terminal_count(terminal_count), .armed(armed), .irq(irq));
   always #5 ref_clk = ~ref_clk;
   function [31:0] exp_cnt(input integer l, input integer k);
      exp_cnt = l - k;
   endfunction
   task bus(input [3:0] a, input [31:0] v, input w);
   begin
      avs_address   <= a;
      avs_writedata <= v;
      avs_write     <= w;
      avs_read      <= !w;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
   end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      bus(a, v, 1'b1);
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
   begin
      checked = checked + 1;
      if (g !== e)
      begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task rc(input [3:0] a, input [31:0] e, input string nm);
   begin
      bus(a, 32'h0, 1'b0);
      chk(nm, e, d);
   end
   endtask
   task pulse(input integer k);
      repeat (k)
      begin
         source_pin <= 1'b1;
         repeat (4) @(posedge ref_clk);
         source_pin <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   task gate(input v);
   begin
      gate_pin <= v;
      repeat (5) @(posedge ref_clk);
   end
   endtask
   task setup(input [15:0] c, input [15:0] l);
   begin
      wr(`CMDSG_ADDR_CONFIG, c);
      wr(`CMDSG_ADDR_LOAD, l);
      wr(`CMDSG_ADDR_CMD, 32'h2);
      wr(`CMDSG_ADDR_CMD, 32'h1);
   end
   endtask
   task report_and_stop;
   begin
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // Watchdog
   initial
   begin
      #500000;
      mismatches = mismatches + 1;
      report_and_stop;
   end
   // Main sequence
   initial
   begin
      seed = $urandom(98324);
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rc(`CMDSG_ADDR_CONFIG, 32'h0, "config");
      rc(`CMDSG_ADDR_MASK, 32'h0, "mask");
      rc(4'h9, 32'h0, "unmapped");
      for (i = 0; i < 9; i = i + 1)
      begin
         wr(`CMDSG_ADDR_CONFIG, (i == 8) ? 32'h2000 : CFGS[i*16 +: 16]);
         rc(`CMDSG_ADDR_STATUS, (i == 8) ? 32'hF2 : (i * 16 + 2), "status");
         chk("mode", (i == 8) ? 32'hF : i, d[7:4]);
      end
      setup(16'h0000, 16'h0000);
      wr(`CMDSG_ADDR_CMD, 32'h4);
      chk("tc", 1, terminal_count);
      wr(`CMDSG_ADDR_LOAD, 32'h5);
      pulse(1);
      chk("tc", 0, terminal_count);
      wr(`CMDSG_ADDR_LOAD, 32'h3);
      wr(`CMDSG_ADDR_CMD, 32'h2);
      wr(`CMDSG_ADDR_IRQ, 32'h7);
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      wr(`CMDSG_ADDR_CMD, 32'h1);
      gate(1);
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h2, "count");
      pulse(2);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h2, "count");
      chk("armed", 0, armed);
      rc(`CMDSG_ADDR_IRQ, 32'h3, "irq_stat");
      chk("irq", 0, irq);
      wr(`CMDSG_ADDR_MASK, 32'h1);
      chk("irq", 1, irq);
      wr(`CMDSG_ADDR_IRQ, 32'h1);
      chk("irq", 0, irq);
      wr(`CMDSG_ADDR_MASK, 32'h0);
      for (i = 0; i < 4; i = i + 1)
      begin
         ld = 2 + $urandom % 8;
         n = $urandom % (ld - 1);
         gate_pin <= $urandom % 2;
         setup(16'h0000, ld[15:0]);
         pulse(n);
         rc(`CMDSG_ADDR_COUNT, exp_cnt(ld, n), "count");
         wr(`CMDSG_ADDR_CMD, 32'h4);
      end
      gate(0);
      setup(16'h20A0, 16'h3);
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      gate(1);
      pulse(3);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      chk("armed", 1, armed);
      setup(16'h2080, 16'h5);
      pulse(2);
      gate(0);
      gate(1);
      rc(`CMDSG_ADDR_HOLD, 32'h3, "hold");
      rc(`CMDSG_ADDR_COUNT, 32'h5, "count");
      pulse(6);
      chk("armed", 0, armed);
      gate(0);
      setup(16'h00C0, 16'h2);
      wr(`CMDSG_ADDR_HOLD, 32'h3);
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h1, "count");
      pulse(1);
      chk("armed", 1, armed);
      gate(1);
      pulse(2);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      pulse(1);
      chk("armed", 0, armed);
      gate(0);
      setup(16'h80E0, 16'h4);
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h4, "count");
      gate(1);
      pulse(2);
      gate(0);
      gate(1);
      rc(`CMDSG_ADDR_HOLD, 32'h2, "hold");
      rc(`CMDSG_ADDR_COUNT, 32'h2, "count");
      pulse(2);
      rc(`CMDSG_ADDR_COUNT, 32'h4, "count");
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      pulse(1);
      rc(`CMDSG_ADDR_COUNT, 32'h3, "count");
      chk("armed", 1, armed);
      report_and_stop;
   end
endmodule
